// [verilog/oag_defs.svh]
// Constants for the operand address generator.
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define OAG_OFF_W 16
`define OAG_BYTE_W 8
`define OAG_NIB_W 4
`define OAG_PHYS_W 20
`define OAG_SEG_SHIFT 4
`define OAG_PTR_W 32
`define OAG_LEN_W 17

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define OAG_ZERO16 16'h0000
`define OAG_ZERO8 8'h00
`define OAG_SEG_PAD 4'h0
`define OAG_BCD_MAX 4'h9
`define OAG_STR_FULL 17'h10000

`endif

// [verilog/oag_pkg.sv]
// Types for the operand address generator.
package oag_pkg;

  // Operand source chosen by the decoder.
  typedef enum logic [1:0] {
    OAG_SRC_REG = 2'b00,
    OAG_SRC_IMM = 2'b01,
    OAG_SRC_MEM = 2'b10
  } oag_src_t;

  // Memory addressing modes.
  typedef enum logic [2:0] {
    OAG_AM_DIRECT = 3'b000,
    OAG_AM_REG_IND = 3'b001,
    OAG_AM_BASED = 3'b010,
    OAG_AM_INDEXED = 3'b011,
    OAG_AM_BASE_IDX = 3'b100,
    OAG_AM_BASE_IDX_DISP = 3'b101
  } oag_amode_t;

  // Segment register selection.
  typedef enum logic [1:0] {
    OAG_SEG_EXTRA = 2'b00,
    OAG_SEG_CODE = 2'b01,
    OAG_SEG_STACK = 2'b10,
    OAG_SEG_DATA = 2'b11
  } oag_seg_t;

endpackage : oag_pkg

// [verilog/oag_ea_adder.sv]
// Three-term effective address adder with 16-bit wrap.
`timescale 1ns/10ps
`include "oag_defs.svh"

module oag_ea_adder #(
  parameter int OFF_W = `OAG_OFF_W
) (
  // Terms and their enables.
  input wire logic [OFF_W-1:0] base_i,
  input wire logic [OFF_W-1:0] index_i,
  input wire logic [OFF_W-1:0] disp_i,
  input wire logic use_base_i,
  input wire logic use_index_i,
  input wire logic use_disp_i,
  // Wrapped sum.
  output logic [OFF_W-1:0] sum_o
);

  // Refuse widths the segment arithmetic cannot serve.
  if (OFF_W != `OAG_OFF_W) begin : g_bad_width
    $error("oag_ea_adder: offset width must be 16");
  end

  // Unused terms are forced to zero before the sum.
  wire [OFF_W-1:0] base_term = use_base_i ? base_i : '0;
  wire [OFF_W-1:0] index_term = use_index_i ? index_i : '0;
  wire [OFF_W-1:0] disp_term = use_disp_i ? disp_i : '0;

  // The target width drops every carry out of the top bit.
  assign sum_o = base_term + index_term + disp_term;

endmodule : oag_ea_adder

// [verilog/oag_top.sv]
// Operand source, effective offset and segment selection for one operand.
//
// Notes on behaviour
// - Register operands come from a general register, byte or word wide.
// - Immediate operands come from the instruction bytes only.
// - Memory offset sums any of displacement, base and index.
// - Carry out of bit 15 is dropped; the offset wraps.
// - Byte displacements are sign-extended to 16 bits.
// - Direct mode offset is the displacement alone.
// - Register indirect offset is exactly one base or index register.
// - Based mode adds displacement and one base register.
// - Indexed mode adds displacement and one index register.
// - Based indexed mode adds base and index, no displacement.
// - Based indexed with displacement adds all three terms.
// - Data references default to the data segment.
// - Instruction fetches always use the code segment, never overridden.
// - Stack operations and base-pointer references use the stack segment.
// - String references indexed by destination index use extra segment.
// - An override prefix replaces the implicit segment for data operands.
// - Signed byte and word operands are two's complement values.
// - Double words pair data register high with accumulator low.
// - Packed decimal bytes hold one digit in each nibble.
// - Pointers are a 16-bit offset or segment plus offset.
// - Strings span one byte up to 64 Kbyte in one segment.
// - Physical address is segment shifted left four plus offset.
`timescale 1ns/10ps
`include "oag_defs.svh"

module oag_top import oag_pkg::*; (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Decoder request.
  input wire logic req_i,
  input wire oag_src_t src_i,
  input wire logic wide_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [15:0] imm_i,
  input wire oag_amode_t amode_i,
  input wire logic [15:0] disp_i,
  input wire logic disp_wide_i,
  input wire logic base_is_ptr_i,
  input wire logic index_is_dest_i,
  input wire logic ind_is_index_i,
  // Access kind and override prefix.
  input wire logic fetch_i,
  input wire logic stack_op_i,
  input wire logic string_dest_i,
  input wire logic ovr_valid_i,
  input wire oag_seg_t ovr_seg_i,
  // General registers.
  input wire logic [15:0] accumulator_reg_i,
  input wire logic [15:0] count_reg_i,
  input wire logic [15:0] data_reg_i,
  input wire logic [15:0] base_reg_i,
  input wire logic [15:0] stack_ptr_i,
  input wire logic [15:0] base_pointer_reg_i,
  input wire logic [15:0] src_index_reg_i,
  input wire logic [15:0] dest_index_reg_i,
  // Segment registers.
  input wire logic [15:0] code_seg_reg_i,
  input wire logic [15:0] data_seg_reg_i,
  input wire logic [15:0] extra_seg_reg_i,
  input wire logic [15:0] stack_seg_reg_i,
  // Pointer and string inputs.
  input wire logic ptr_far_i,
  input wire logic [31:0] ptr_data_i,
  input wire logic [15:0] str_count_i,
  // Operand results.
  output logic done_o,
  output logic [15:0] opnd_o,
  output logic [15:0] opnd_sext_o,
  output logic [31:0] dword_o,
  output logic [3:0] bcd_hi_o,
  output logic [3:0] bcd_lo_o,
  output logic bcd_ok_o,
  // Address results.
  output logic mem_valid_o,
  output oag_seg_t seg_sel_o,
  output logic [15:0] seg_o,
  output logic [15:0] off_o,
  output logic [19:0] phys_o,
  // Pointer and string results.
  output logic [15:0] ptr_seg_o,
  output logic [15:0] ptr_off_o,
  output logic [16:0] str_bytes_o
);

  // --------------------------------------------------------------------
  // Register operand selection
  // --------------------------------------------------------------------

  // General registers in encoding order, low byte halves first.
  wire [15:0] gpr [8];
  assign gpr[0] = accumulator_reg_i;
  assign gpr[1] = count_reg_i;
  assign gpr[2] = data_reg_i;
  assign gpr[3] = base_reg_i;
  assign gpr[4] = stack_ptr_i;
  assign gpr[5] = base_pointer_reg_i;
  assign gpr[6] = src_index_reg_i;
  assign gpr[7] = dest_index_reg_i;

  // Byte codes 4..7 name the high halves of the first four registers.
  wire [2:0] byte_word = {1'b0, reg_sel_i[1:0]};
  wire [15:0] byte_src = gpr[byte_word];
  wire [7:0] reg_byte = reg_sel_i[2] ? byte_src[15:8] : byte_src[7:0];
  wire [15:0] reg_val = wide_i ? gpr[reg_sel_i]
                               : {`OAG_ZERO8, reg_byte};

  // Immediate data is taken from the instruction bytes alone.
  wire [15:0] imm_val = wide_i ? imm_i
                               : {`OAG_ZERO8, imm_i[7:0]};

  // Operand value by source; memory data arrives later over the bus.
  wire is_reg = (src_i == OAG_SRC_REG);
  wire is_imm = (src_i == OAG_SRC_IMM);
  wire is_mem = (src_i == OAG_SRC_MEM);
  wire [15:0] opnd_val = is_reg ? reg_val
                       : is_imm ? imm_val : `OAG_ZERO16;

  // Byte operands widened as two's complement for signed arithmetic.
  wire [15:0] opnd_sext = wide_i ? opnd_val
                        : {{8{opnd_val[7]}}, opnd_val[7:0]};

  // Packed decimal digits from the low operand byte.
  wire [3:0] bcd_hi = opnd_val[7:4];
  wire [3:0] bcd_lo = opnd_val[3:0];
  wire bcd_ok = (bcd_hi <= `OAG_BCD_MAX) && (bcd_lo <= `OAG_BCD_MAX);

  // --------------------------------------------------------------------
  // Effective address
  // --------------------------------------------------------------------

  // Byte displacements are sign-extended before the add.
  wire [15:0] disp_ext = disp_wide_i ? disp_i
                       : {{8{disp_i[7]}}, disp_i[7:0]};

  // Term enables per addressing mode.
  wire am_dir = (amode_i == OAG_AM_DIRECT);
  wire am_ind = (amode_i == OAG_AM_REG_IND);
  wire am_bas = (amode_i == OAG_AM_BASED);
  wire am_idx = (amode_i == OAG_AM_INDEXED);
  wire am_bi = (amode_i == OAG_AM_BASE_IDX);
  wire am_bid = (amode_i == OAG_AM_BASE_IDX_DISP);
  wire use_disp = am_dir | am_bas | am_idx | am_bid;
  wire use_base = (am_ind & ~ind_is_index_i) | am_bas
                | am_bi | am_bid;
  wire use_index = (am_ind & ind_is_index_i) | am_idx
                 | am_bi | am_bid;

  // Base is base or base pointer; index is source or destination.
  wire [15:0] base_val = base_is_ptr_i ? base_pointer_reg_i : base_reg_i;
  wire [15:0] index_val = index_is_dest_i ? dest_index_reg_i
                                        : src_index_reg_i;

  // Wrapping three-term sum.
  wire [15:0] ea_sum;
  oag_ea_adder #(
    .OFF_W(`OAG_OFF_W)
  ) u_ea (
    .base_i(base_val),
    .index_i(index_val),
    .disp_i(disp_ext),
    .use_base_i(use_base),
    .use_index_i(use_index),
    .use_disp_i(use_disp),
    .sum_o(ea_sum)
  );

  // --------------------------------------------------------------------
  // Segment selection
  // --------------------------------------------------------------------

  // Implicit segment: stack for push, pop and base pointer references,
  // extra for destination-indexed strings, data otherwise.
  wire uses_bptr = use_base & base_is_ptr_i;
  wire imp_stack = stack_op_i | uses_bptr;
  wire imp_extra = string_dest_i & use_index & index_is_dest_i;
  wire oag_seg_t imp_seg = imp_stack ? OAG_SEG_STACK
                         : imp_extra ? OAG_SEG_EXTRA
                         : OAG_SEG_DATA;

  // Fetches, pushes, pops and string destinations cannot be redirected.
  wire ovr_ok = ovr_valid_i & ~stack_op_i & ~imp_extra;
  wire oag_seg_t sel_seg = fetch_i ? OAG_SEG_CODE
                         : ovr_ok ? ovr_seg_i
                         : imp_seg;

  // Segment value for the chosen register.
  wire [15:0] seg_val = (sel_seg == OAG_SEG_CODE) ? code_seg_reg_i
                      : (sel_seg == OAG_SEG_STACK) ? stack_seg_reg_i
                      : (sel_seg == OAG_SEG_EXTRA) ? extra_seg_reg_i
                      : data_seg_reg_i;

  // Physical address from shifted segment plus offset.
  wire [19:0] phys_val = {seg_val, `OAG_SEG_PAD}
                       + {`OAG_SEG_PAD, ea_sum};

  // --------------------------------------------------------------------
  // Pairs, pointers and strings
  // --------------------------------------------------------------------

  // Double word with data register above accumulator.
  wire [31:0] dword_val = {data_reg_i, accumulator_reg_i};

  // A far pointer carries segment high and offset low.
  wire [15:0] ptr_seg = ptr_far_i ? ptr_data_i[31:16]
                                  : `OAG_ZERO16;
  wire [15:0] ptr_off = ptr_data_i[15:0];

  // A count of zero stands for a full 64 Kbyte segment.
  wire [16:0] str_bytes = (str_count_i == `OAG_ZERO16) ? `OAG_STR_FULL
                        : {1'b0, str_count_i};

  // --------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------

  logic done_q;
  logic mem_q;

  // Handshake flags, cleared by reset.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      done_q <= 1'b0;
      mem_q <= 1'b0;
    end else begin
      done_q <= req_i;
      mem_q <= req_i & is_mem;
    end
  end

  // Address results load together so segment and offset stay paired.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      seg_sel_o <= OAG_SEG_DATA;
      seg_o <= `OAG_ZERO16;
      off_o <= `OAG_ZERO16;
      phys_o <= '0;
    end else if (req_i) begin
      seg_sel_o <= sel_seg;
      seg_o <= seg_val;
      off_o <= ea_sum;
      phys_o <= phys_val;
    end
  end

  // Operand data results.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      opnd_o <= `OAG_ZERO16;
      opnd_sext_o <= `OAG_ZERO16;
      bcd_hi_o <= '0;
      bcd_lo_o <= '0;
      bcd_ok_o <= 1'b0;
    end else if (req_i) begin
      opnd_o <= opnd_val;
      opnd_sext_o <= opnd_sext;
      bcd_hi_o <= bcd_hi;
      bcd_lo_o <= bcd_lo;
      bcd_ok_o <= bcd_ok;
    end
  end

  // Pair, pointer and string results.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dword_o <= '0;
      ptr_seg_o <= `OAG_ZERO16;
      ptr_off_o <= `OAG_ZERO16;
      str_bytes_o <= '0;
    end else if (req_i) begin
      dword_o <= dword_val;
      ptr_seg_o <= ptr_seg;
      ptr_off_o <= ptr_off;
      str_bytes_o <= str_bytes;
    end
  end

  assign done_o = done_q;
  assign mem_valid_o = mem_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------

  property p_disp_only;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && am_dir |=> off_o == $past(disp_ext);
  endproperty
  a_disp_only: assert property (p_disp_only)
    else $error("direct offset differs from displacement");

  property p_sign_ext;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && am_dir && !disp_wide_i |=>
      off_o[15:8] == {8{off_o[7]}};
  endproperty
  a_sign_ext: assert property (p_sign_ext)
    else $error("byte displacement not sign extended");

  property p_base_idx;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && am_bi |=>
      off_o == 16'($past(base_val) + $past(index_val));
  endproperty
  a_base_idx: assert property (p_base_idx)
    else $error("based indexed offset wrong");

  property p_all_three;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && am_bid |=> off_o == 16'($past(base_val)
      + $past(index_val) + $past(disp_ext));
  endproperty
  a_all_three: assert property (p_all_three)
    else $error("three-term offset wrong");

  property p_fetch_code;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && fetch_i |=> seg_sel_o == OAG_SEG_CODE;
  endproperty
  a_fetch_code: assert property (p_fetch_code)
    else $error("fetch not on code segment");

  property p_stack_seg;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && !fetch_i && stack_op_i |=> seg_sel_o == OAG_SEG_STACK;
  endproperty
  a_stack_seg: assert property (p_stack_seg)
    else $error("stack access not on stack segment");

  property p_override;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && !fetch_i && ovr_ok |=> seg_sel_o == $past(ovr_seg_i);
  endproperty
  a_override: assert property (p_override)
    else $error("override segment ignored");

  property p_default_data;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && !fetch_i && !ovr_valid_i && !imp_stack && !imp_extra
      |=> seg_sel_o == OAG_SEG_DATA;
  endproperty
  a_default_data: assert property (p_default_data)
    else $error("default segment is not data");

  property p_phys;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    mem_valid_o |-> phys_o == {seg_o, 4'h0} + {4'h0, off_o};
  endproperty
  a_phys: assert property (p_phys)
    else $error("physical address mismatch");

  property p_mem_pulse;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && is_mem |=> mem_valid_o && done_o;
  endproperty
  a_mem_pulse: assert property (p_mem_pulse)
    else $error("memory result not flagged");

  c_wrap: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i && am_bid && (ea_sum < base_val));
  c_override: cover property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) req_i && ovr_ok && is_mem);
  c_string_dest: cover property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) req_i && imp_extra);

endmodule : oag_top

// [dv/oag_regs_model.sv]
// Register file model standing in for the decoder side of the block.
`timescale 1ns/10ps

module oag_regs_model (
  // General registers.
  output logic [15:0] acc_o,
  output logic [15:0] cnt_o,
  output logic [15:0] dat_o,
  output logic [15:0] bas_o,
  output logic [15:0] spt_o,
  output logic [15:0] bpr_o,
  output logic [15:0] sir_o,
  output logic [15:0] dst_o,
  // Segment registers.
  output logic [15:0] sc_o,
  output logic [15:0] sd_o,
  output logic [15:0] sx_o,
  output logic [15:0] sk_o
);
  // Contents are held steady; base and index values push sums past bit 15.
  assign acc_o = 16'h1234;
  assign cnt_o = 16'h2345;
  assign dat_o = 16'hFEDC;
  assign bas_o = 16'hFFF0;
  assign spt_o = 16'h0100;
  assign bpr_o = 16'h8000;
  assign sir_o = 16'h0011;
  assign dst_o = 16'h7F00;
  // Segment values are all distinct so a wrong choice shows.
  assign sc_o = 16'h1000;
  assign sd_o = 16'h12A4;
  assign sx_o = 16'h3000;
  assign sk_o = 16'h4000;
endmodule : oag_regs_model

// [dv/oag_top_bench.sv]
// Self-checking bench for the operand address generator.
`timescale 1ns/10ps

module oag_top_bench import oag_pkg::*;;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk, rst, req, wide, dw, use_bpr, use_dst, ind, fetch, stk, sdi;
  logic ovr, pfar, done, bok, mval;
  oag_src_t src;
  oag_amode_t am;
  oag_seg_t oseg, ssel;
  logic [2:0] rsel;
  logic [3:0] bhi, blo;
  logic [15:0] imm, disp, scnt, opnd, opnd_sx, sval, off, pseg, poff;
  logic [15:0] acc, cnt, dat, bas, spt, bpr, sir, dst, sc, sd, sx, sk;
  logic [16:0] sbytes;
  logic [19:0] phys;
  logic [31:0] pdata, dword;
  int n_mismatch = 0;
  int comparisons = 0;

  // Register file on the decoder side.
  oag_regs_model regs (.acc_o(acc), .cnt_o(cnt), .dat_o(dat),
    .bas_o(bas), .spt_o(spt), .bpr_o(bpr), .sir_o(sir), .dst_o(dst),
    .sc_o(sc), .sd_o(sd), .sx_o(sx), .sk_o(sk));

  // Block under test.
  oag_top dut (.sys_clk_i(clk), .sys_rst_i(rst), .req_i(req),
    .src_i(src), .wide_i(wide), .reg_sel_i(rsel), .imm_i(imm),
    .amode_i(am), .disp_i(disp), .disp_wide_i(dw),
    .base_is_ptr_i(use_bpr), .index_is_dest_i(use_dst),
    .ind_is_index_i(ind), .fetch_i(fetch), .stack_op_i(stk),
    .string_dest_i(sdi),
    .ovr_valid_i(ovr), .ovr_seg_i(oseg), .accumulator_reg_i(acc),
    .count_reg_i(cnt), .data_reg_i(dat), .base_reg_i(bas),
    .stack_ptr_i(spt), .base_pointer_reg_i(bpr), .src_index_reg_i(sir),
    .dest_index_reg_i(dst), .code_seg_reg_i(sc), .data_seg_reg_i(sd),
    .extra_seg_reg_i(sx), .stack_seg_reg_i(sk), .ptr_far_i(pfar),
    .ptr_data_i(pdata), .str_count_i(scnt), .done_o(done), .opnd_o(opnd),
    .opnd_sext_o(opnd_sx), .dword_o(dword), .bcd_hi_o(bhi),
    .bcd_lo_o(blo), .bcd_ok_o(bok), .mem_valid_o(mval), .seg_sel_o(ssel),
    .seg_o(sval), .off_o(off), .phys_o(phys), .ptr_seg_o(pseg),
    .ptr_off_o(poff), .str_bytes_o(sbytes));

  // Clock at 200 MHz.
  always #2.5 clk = ~clk;

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Sets up a register or immediate request at a rising edge.
  task automatic setr(input oag_src_t s, input logic w,
                      input logic [2:0] r, input logic [15:0] v);
    @(posedge clk);
    src <= s;
    wide <= w;
    rsel <= r;
    imm <= v;
  endtask : setr

  // Sets up a memory request at a rising edge.
  task automatic setm(input oag_amode_t a, input logic [15:0] d,
                      input logic w, b, x, n);
    @(posedge clk);
    src <= OAG_SRC_MEM;
    am <= a;
    disp <= d;
    dw <= w;
    use_bpr <= b;
    use_dst <= x;
    ind <= n;
  endtask : setm

  // Sets the access kind and override prefix in the same time step.
  task automatic setk(input logic f, s, t, o, input oag_seg_t g);
    fetch <= f;
    stk <= s;
    sdi <= t;
    ovr <= o;
    oseg <= g;
  endtask : setk

  // Raises the request for one edge and lets the answer settle.
  task automatic fire;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask : fire

  // Judges a memory answer; segment, offset and address belong together.
  task automatic chkm(input logic [15:0] eoff, input oag_seg_t esel);
    logic [15:0] eseg;
    logic [19:0] ephys;
    eseg = (esel == OAG_SEG_CODE) ? 16'h1000 :
           (esel == OAG_SEG_STACK) ? 16'h4000 :
           (esel == OAG_SEG_EXTRA) ? 16'h3000 : 16'h12A4;
    ephys = {eseg, 4'h0} + {4'h0, eoff};
    chk("done", 32'h1, 32'(done));
    chk("mem valid", 32'h1, 32'(mval));
    chk("offset", 32'(eoff), 32'(off));
    chk("seg code", 32'(esel), 32'(ssel));
    chk("seg value", 32'(eseg), 32'(sval));
    chk("phys", 32'(ephys), 32'(phys));
  endtask : chkm

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Register operands, byte and word, with signed and packed views.
  task automatic t_reg;
    setr(OAG_SRC_REG, 1'b1, 3'd3, 16'h0000);
    fire;
    chk("word reg", 32'hFFF0, 32'(opnd));
    chk("dword", 32'hFEDC_1234, dword);
    chk("no mem", 32'h0, 32'(mval));
    setr(OAG_SRC_REG, 1'b0, 3'd6, 16'h0000);
    fire;
    chk("byte reg", 32'h00FE, 32'(opnd));
    chk("signed", 32'hFFFE, 32'(opnd_sx));
    chk("nibbles", 32'h0F_E0, {20'h0, bhi, blo, 3'h0, bok});
    setr(OAG_SRC_REG, 1'b0, 3'd0, 16'h0000);
    fire;
    chk("byte low", 32'h0034, 32'(opnd_sx));
    chk("nibbles", 32'h03_41, {20'h0, bhi, blo, 3'h0, bok});
    $display("test reg done");
  endtask : t_reg

  // Immediate operand is the instruction bytes, not a register.
  task automatic t_imm;
    setr(OAG_SRC_IMM, 1'b1, 3'd3, 16'hA5C3);
    fire;
    chk("immediate", 32'hA5C3, 32'(opnd));
    chk("no mem", 32'h0, 32'(mval));
    $display("test imm done");
  endtask : t_imm

  // Far and near pointers, longest and shortest strings.
  task automatic t_ptr;
    setr(OAG_SRC_REG, 1'b1, 3'd0, 16'h0000);
    pfar <= 1'b1;
    pdata <= 32'h1234_5678;
    scnt <= 16'h0000;
    fire;
    chk("far seg", 32'h1234, 32'(pseg));
    chk("far off", 32'h5678, 32'(poff));
    chk("str full", 32'h10000, 32'(sbytes));
    setr(OAG_SRC_REG, 1'b1, 3'd0, 16'h0000);
    pfar <= 1'b0;
    scnt <= 16'h0001;
    fire;
    chk("near seg", 32'h0, 32'(pseg));
    chk("str one", 32'h1, 32'(sbytes));
    $display("test ptr done");
  endtask : t_ptr

  // All six modes; upper displacement bits are junk when byte wide.
  task automatic t_modes;
    setm(OAG_AM_DIRECT, 16'h5580, 1'b0, 1'b0, 1'b0, 1'b0);
    setk(1'b0, 1'b0, 1'b0, 1'b0, OAG_SEG_DATA);
    fire;
    chkm(16'hFF80, OAG_SEG_DATA);
    setm(OAG_AM_REG_IND, 16'h0040, 1'b1, 1'b0, 1'b1, 1'b1);
    fire;
    chkm(16'h7F00, OAG_SEG_DATA);
    setm(OAG_AM_REG_IND, 16'h0040, 1'b1, 1'b0, 1'b0, 1'b0);
    fire;
    chkm(16'hFFF0, OAG_SEG_DATA);
    setm(OAG_AM_BASED, 16'h1234, 1'b1, 1'b1, 1'b0, 1'b0);
    fire;
    chkm(16'h9234, OAG_SEG_STACK);
    setm(OAG_AM_INDEXED, 16'h7711, 1'b0, 1'b0, 1'b0, 1'b0);
    fire;
    chkm(16'h0022, OAG_SEG_DATA);
    setm(OAG_AM_BASE_IDX, 16'h0FFF, 1'b1, 1'b0, 1'b1, 1'b0);
    fire;
    chkm(16'h7EF0, OAG_SEG_DATA);
    setm(OAG_AM_BASE_IDX_DISP, 16'h00FF, 1'b0, 1'b0, 1'b0, 1'b0);
    fire;
    chkm(16'h0000, OAG_SEG_DATA);
    $display("test modes done");
  endtask : t_modes

  // Segment choice under fetch, stack, string and override.
  task automatic t_seg;
    setm(OAG_AM_DIRECT, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b0);
    setk(1'b1, 1'b0, 1'b0, 1'b1, OAG_SEG_EXTRA);
    fire;
    chkm(16'h0010, OAG_SEG_CODE);
    setm(OAG_AM_DIRECT, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b0);
    setk(1'b0, 1'b0, 1'b0, 1'b1, OAG_SEG_EXTRA);
    fire;
    chkm(16'h0010, OAG_SEG_EXTRA);
    setm(OAG_AM_DIRECT, 16'h0020, 1'b1, 1'b0, 1'b0, 1'b0);
    setk(1'b0, 1'b1, 1'b0, 1'b1, OAG_SEG_DATA);
    fire;
    chkm(16'h0020, OAG_SEG_STACK);
    setm(OAG_AM_REG_IND, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b1);
    setk(1'b0, 1'b0, 1'b1, 1'b1, OAG_SEG_CODE);
    fire;
    chkm(16'h7F00, OAG_SEG_EXTRA);
    setm(OAG_AM_REG_IND, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b0);
    setk(1'b0, 1'b0, 1'b0, 1'b1, OAG_SEG_CODE);
    fire;
    chkm(16'h8000, OAG_SEG_CODE);
    $display("test seg done");
  endtask : t_seg

  // Back-to-back requests, pulse length, then a reset in mid-run.
  task automatic t_b2b;
    setm(OAG_AM_DIRECT, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b0);
    setk(1'b0, 1'b0, 1'b0, 1'b0, OAG_SEG_DATA);
    req <= 1'b1;
    @(posedge clk);
    disp <= 16'h0020;
    #1;
    chkm(16'h0010, OAG_SEG_DATA);
    fire;
    chkm(16'h0020, OAG_SEG_DATA);
    @(posedge clk);
    #1;
    chk("done drop", 32'h0, 32'({done, mval}));
    chk("off hold", 32'h0020, 32'(off));
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset off", 32'h0, 32'(off));
    chk("reset seg", 32'(OAG_SEG_DATA), 32'(ssel));
    $display("test b2b done");
  endtask : t_b2b

  // ------------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------------
  // Inputs get values at time zero, reset holds for four cycles.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = 1'b0;
    src = OAG_SRC_REG;
    am = OAG_AM_DIRECT;
    oseg = OAG_SEG_DATA;
    {wide, dw, use_bpr, use_dst, ind, fetch, stk, sdi, ovr, pfar} = '0;
    rsel = 3'd0;
    imm = 16'h0000;
    disp = 16'h0000;
    scnt = 16'h0000;
    pdata = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reg;
    t_imm;
    t_ptr;
    t_modes;
    t_seg;
    t_b2b;
    wrap_up;
  end

  // The run needs well under a hundred cycles; cut a hang at 2000.
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule : oag_top_bench
